//--- rtl/dat_chan_irq.sv
// What this block does
// [R1] Capture while flag set latches new value, flag stays set.
// [R2] Compare match while flag set is processed, flag stays set.
// [R3] Toggle match while flag set still toggles output, flag stays set.
// [R4] Internal compare match while flag set is handled, flag stays set.
// [R5] Flag clears only after a read seeing one, then a zero write.
// [R6] Event between that read and write cancels the clear.
// [R7] Flag reads one after an event, zero since last clear.
// [R8] Level zero disables requests; one to seven give rising priority.
// [R9] Level field readable, writable anytime, zero after reset.
// [R10] Level in channel A register applies to both channels.
// [R11] Arbitration bit is the msb above the three-bit arbitration field.
// [R12] Software gives every requesting module a distinct arbitration number.
// [R13] Equal-priority simultaneous requests contend by arbitration number.
// [R14] Arbitration bit in channel A register serves both channels.
// [R15] Only hardware sets the flag; software or reset clears it.
// [R16] Request when flag set, enable one and level nonzero.
// [R17] Request drops once flag cleared or enable written zero.
//
// Channel A flag, level and arbitration, with AXI4-Lite registers.
// Assumes events and channel B flag and enable arrive on core_clk_in already.
`default_nettype none
module dat_chan_irq
  import dat_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Channel A events and data, channel B flag and enable
  input wire logic capture_evt_in,
  input wire logic compare_evt_in,
  input wire logic [DATA_W-1:0] capture_value_in,
  input wire logic chb_flag_in,
  input wire logic chb_ien_in,
  // Channel outputs
  output logic [DATA_W-1:0] capture_latch_out,
  output logic compare_pin_out,
  output logic compare_hit_out,
  // Module bus request
  output logic bus_irq_req_out,
  output logic [2:0] bus_irq_level_out,
  output logic [3:0] bus_arb_number_out,
  // Host interrupt
  output logic irq_out
);
  logic flag_a;
  logic flag_event;
  logic flag_read;
  logic flag_wzero;
  logic [2:0] level_r;
  logic arb_msb_r;
  logic [2:0] arb_low_r;
  logic ien_r;
  dat_mode_t mode_r;
  logic [DAT_IRQ_BITS-1:0] stat_r;
  logic [DAT_IRQ_BITS-1:0] mask_r;
  logic [DAT_IRQ_BITS-1:0] stat_set;
  logic flag_b_d_r;
  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic wr_go;
  logic rd_go;
  logic [15:0] ctrl_view;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == DAT_CTRL_A_OFS) || (a == DAT_IRQ_STAT_OFS) ||
                 (a == DAT_IRQ_MASK_OFS) || (a == DAT_ARB_OFS);
  endfunction : addr_known

  // Every mode's event sets the flag regardless of its current state
  assign flag_event = (mode_r == DAT_MODE_CAPTURE) ? capture_evt_in
                                                   : compare_evt_in; // [R7]
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid_out;
  assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
  assign flag_read = rd_go && (s_axi_araddr_in == DAT_CTRL_A_OFS);
  assign flag_wzero = wr_go && (aw_addr_r == DAT_CTRL_A_OFS) &&
                      w_strb_r[1] && !w_data_r[DAT_FLAG_BIT];

  dat_flag_ctl u_flag (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .event_in(flag_event),
    .read_in(flag_read),
    .write_zero_in(flag_wzero),
    .flag_out(flag_a)
  );

  always_comb begin
    ctrl_view = DAT_CTRL_A_RST;
    ctrl_view[DAT_FLAG_BIT] = flag_a; // [R7]
    ctrl_view[DAT_LVL_HI:DAT_LVL_LO] = level_r; // [R9]
    ctrl_view[DAT_ARB_MSB_BIT] = arb_msb_r;
    ctrl_view[DAT_IEN_BIT] = ien_r;
    ctrl_view[DAT_MODE_HI:DAT_MODE_LO] = mode_r;
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      s_axi_awready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_have_r && !s_axi_awready_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_wready_out <= !w_have_r && !s_axi_wready_out;
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= DAT_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= addr_known(aw_addr_r) ? DAT_RESP_OKAY
                                               : DAT_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Control fields; the level and arbitration bit are shared by both channels
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_r <= DAT_CTRL_A_RST[DAT_LVL_HI:DAT_LVL_LO]; // [R9]
      arb_msb_r <= DAT_CTRL_A_RST[DAT_ARB_MSB_BIT];
      ien_r <= DAT_CTRL_A_RST[DAT_IEN_BIT];
      mode_r <= dat_mode_t'(DAT_CTRL_A_RST[DAT_MODE_HI:DAT_MODE_LO]);
    end else if (wr_go && aw_addr_r == DAT_CTRL_A_OFS) begin
      if (w_strb_r[1]) begin
        level_r <= w_data_r[DAT_LVL_HI:DAT_LVL_LO]; // [R9]
        arb_msb_r <= w_data_r[DAT_ARB_MSB_BIT]; // [R14]
        ien_r <= w_data_r[DAT_IEN_BIT];
      end
      if (w_strb_r[0]) begin
        mode_r <= dat_mode_t'(w_data_r[DAT_MODE_HI:DAT_MODE_LO]);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arb_low_r <= DAT_ARB_LOW_RST;
      mask_r <= DAT_IRQ_MASK_RST;
    end else if (wr_go && w_strb_r[0]) begin
      if (aw_addr_r == DAT_ARB_OFS) begin
        arb_low_r <= w_data_r[2:0];
      end
      if (aw_addr_r == DAT_IRQ_MASK_OFS) begin
        mask_r <= w_data_r[DAT_IRQ_BITS-1:0];
      end
    end
  end

  // Sticky status: channel A event of the selected mode and rising flag of B, write one to clear, set wins
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_b_d_r <= 1'b0;
    end else begin
      flag_b_d_r <= chb_flag_in;
    end
  end

  always_comb begin
    stat_set = '0;
    stat_set[DAT_IRQ_FLAG_A] = flag_event;
    stat_set[DAT_IRQ_FLAG_B] = chb_flag_in && !flag_b_d_r;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_r <= '0;
    end else if (wr_go && aw_addr_r == DAT_IRQ_STAT_OFS && w_strb_r[0]) begin
      stat_r <= (stat_r & ~w_data_r[DAT_IRQ_BITS-1:0]) | stat_set;
    end else begin
      stat_r <= stat_r | stat_set;
    end
  end

  // Read channel
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= DAT_RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
      if (rd_go) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= addr_known(s_axi_araddr_in) ? DAT_RESP_OKAY
                                                       : DAT_RESP_SLVERR;
        unique case (s_axi_araddr_in)
          DAT_CTRL_A_OFS: s_axi_rdata_out <= {16'h0000, ctrl_view};
          DAT_IRQ_STAT_OFS: s_axi_rdata_out <= {30'h0, stat_r};
          DAT_IRQ_MASK_OFS: s_axi_rdata_out <= {30'h0, mask_r};
          DAT_ARB_OFS: s_axi_rdata_out <= {29'h0, arb_low_r};
          default: s_axi_rdata_out <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // Capture latch and compare pin keep working with the flag set
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_latch_out <= '0;
      compare_pin_out <= 1'b0;
      compare_hit_out <= 1'b0;
    end else begin
      compare_hit_out <= 1'b0;
      unique case (mode_r)
        DAT_MODE_CAPTURE: begin
          if (capture_evt_in) begin
            capture_latch_out <= capture_value_in; // [R1]
          end
        end
        DAT_MODE_COMPARE: begin
          if (compare_evt_in) begin
            compare_pin_out <= 1'b1; // [R2]
          end
        end
        DAT_MODE_TOGGLE: begin
          if (compare_evt_in) begin
            compare_pin_out <= !compare_pin_out; // [R3]
          end
        end
        DAT_MODE_PULSE: begin
          compare_hit_out <= compare_evt_in; // [R4]
        end
      endcase
    end
  end

  // Module bus request: shared level and 4-bit arbitration number
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_irq_req_out <= 1'b0;
      bus_irq_level_out <= DAT_LVL_OFF;
      bus_arb_number_out <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      // A zero level stops both channels from requesting
      bus_irq_req_out <= (level_r != DAT_LVL_OFF) &&
        ((flag_a && ien_r) || (chb_flag_in && chb_ien_in)); // [R16] [R17]
      bus_irq_level_out <= level_r; // [R8] [R10]
      bus_arb_number_out <= {arb_msb_r, arb_low_r}; // [R11] [R13]
      irq_out <= |(stat_r & mask_r);
    end
  end
endmodule : dat_chan_irq
`default_nettype wire

//--- rtl/dat_pkg.sv
// Constants for the dual action timer channel A flag and interrupt block.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
`default_nettype none
package dat_pkg;
  // Register byte addresses
  localparam logic [7:0] DAT_CTRL_A_OFS = 8'h00;
  localparam logic [7:0] DAT_IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] DAT_IRQ_MASK_OFS = 8'h08;
  localparam logic [7:0] DAT_ARB_OFS = 8'h0c;
  // Channel A control/status field positions
  localparam int DAT_FLAG_BIT = 15;
  localparam int DAT_LVL_HI = 14;
  localparam int DAT_LVL_LO = 12;
  localparam int DAT_ARB_MSB_BIT = 11;
  localparam int DAT_IEN_BIT = 10;
  localparam int DAT_MODE_HI = 1;
  localparam int DAT_MODE_LO = 0;
  localparam logic [15:0] DAT_CTRL_A_RST = 16'h0000;
  // Arbitration register: low three bits of the arbitration number
  localparam logic [2:0] DAT_ARB_LOW_RST = 3'h0;
  // Interrupt status bits
  localparam int DAT_IRQ_FLAG_A = 0;
  localparam int DAT_IRQ_FLAG_B = 1;
  localparam int DAT_IRQ_BITS = 2;
  localparam logic [1:0] DAT_IRQ_MASK_RST = 2'h0;
  localparam logic [2:0] DAT_LVL_OFF = 3'h0;
  // AXI responses
  localparam logic [1:0] DAT_RESP_OKAY = 2'h0;
  localparam logic [1:0] DAT_RESP_SLVERR = 2'h2;
  // Channel modes
  typedef enum logic [1:0] {
    DAT_MODE_CAPTURE = 2'h0,
    DAT_MODE_COMPARE = 2'h1,
    DAT_MODE_TOGGLE = 2'h2,
    DAT_MODE_PULSE = 2'h3
  } dat_mode_t;
endpackage : dat_pkg
`default_nettype wire

//--- rtl/dat_flag_ctl.sv
// Sticky event flag with read-then-write-zero clearing.
// Assumes event and access strobes are one-cycle pulses on core_clk_in.
`default_nettype none
module dat_flag_ctl (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Hardware event and software access
  input wire logic event_in,
  input wire logic read_in,
  input wire logic write_zero_in,
  // State
  output logic flag_out
);
  logic armed_r;

  // Set wins over clear; only events set, only writes or reset clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (event_in) begin
      flag_out <= 1'b1; // [R15]
    end else if (write_zero_in && armed_r) begin
      flag_out <= 1'b0; // [R5]
    end
  end

  // Armed by a read that saw one; any event in between disarms
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_r <= 1'b0;
    end else if (event_in) begin
      armed_r <= 1'b0; // [R6]
    end else if (read_in) begin
      armed_r <= flag_out; // [R5]
    end else if (write_zero_in) begin
      armed_r <= 1'b0;
    end
  end
endmodule : dat_flag_ctl
`default_nettype wire

//--- dv/dat_chan_irq_chk.sv
// Port checker for the channel A flag and interrupt block.
// Assumes one clock domain; bound to every dat_chan_irq instance.
`default_nettype none
module dat_chan_irq_chk #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Register read channel
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  // Channel events and outputs
  input wire logic capture_evt_in,
  input wire logic compare_evt_in,
  input wire logic chb_flag_in,
  input wire logic chb_ien_in,
  input wire logic [DATA_W-1:0] capture_latch_out,
  input wire logic compare_pin_out,
  input wire logic compare_hit_out,
  input wire logic bus_irq_req_out,
  input wire logic [2:0] bus_irq_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  lat_src_a: assert property (!$stable(capture_latch_out)
    |-> $past(capture_evt_in)) else $error("latch moved alone");
  hit_src_a: assert property (compare_hit_out
    |-> $past(compare_evt_in)) else $error("hit without match");
  pin_src_a: assert property ($changed(compare_pin_out)
    |-> $past(compare_evt_in)) else $error("pin moved alone");
  req_lvl_a: assert property (bus_irq_req_out
    |-> bus_irq_level_out != 3'h0 || $past(bus_irq_level_out) != 3'h0)
    else $error("request at level zero");
  lvl_off_a: assert property ((bus_irq_level_out == 3'h0) [*2]
    |-> !bus_irq_req_out) else $error("request while disabled");
  chb_req_a: assert property ((chb_flag_in && chb_ien_in
    && bus_irq_level_out != 3'h0) [*2] |-> bus_irq_req_out)
    else $error("channel B request missing");
  rd_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped");
  cover property (compare_hit_out);
  cover property (bus_irq_req_out && bus_irq_level_out == 3'h7);
  cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule : dat_chan_irq_chk
bind dat_chan_irq dat_chan_irq_chk #(.DATA_W(DATA_W)) i_chk (
  .core_clk_in, .rst_n_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .capture_evt_in,
  .compare_evt_in, .chb_flag_in, .chb_ien_in, .capture_latch_out,
  .compare_pin_out, .compare_hit_out, .bus_irq_req_out, .bus_irq_level_out
);
`default_nettype wire

//--- dv/dat_chb_model.sv
// Channel B stand-in: sticky event flag seen by the request logic.
// Assumes set and clear strobes come from the bench on core_clk_in.
`default_nettype none
module dat_chb_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Bench controls
  input wire logic set_in,
  input wire logic clr_in,
  // Flag toward the block
  output logic chb_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Set wins over clear, like the channel A flag
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chb_flag_out <= 1'h0;
    end else begin
      chb_flag_out <= set_in | (chb_flag_out & ~clr_in);
    end
  end
endmodule : dat_chb_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the channel A flag and interrupt block.
// Assumes the checker binds itself and channel B comes from its model.
`default_nettype none
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); \
  end \
end
module tb_top
  import dat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'h0, rst_n_in = 1'h0;
  logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
  logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
  logic s_axi_rready_in = 1'h0, chb_ien_in = 1'h0;
  logic [31:0] s_axi_wdata_in = '0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic capture_evt_in = 1'h0, compare_evt_in = 1'h0;
  logic [15:0] capture_value_in = '0;
  logic chb_set = 1'h0, chb_clr = 1'h0;
  wire logic chb_flag_in, s_axi_awready_out, s_axi_wready_out;
  wire logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire logic compare_pin_out, compare_hit_out, bus_irq_req_out, irq_out;
  wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire logic [31:0] s_axi_rdata_out;
  wire logic [15:0] capture_latch_out;
  wire logic [2:0] bus_irq_level_out;
  wire logic [3:0] bus_arb_number_out;
  int bad_count = 0, n_compared = 0, cyc = 0;
  logic [31:0] seed = 32'h50;
  logic [33:0] q_rd[$];
  logic [1:0] q_wr[$];
  logic [33:0] e_rd;
  logic [1:0] e_wr;

  dat_chan_irq #(.DATA_W(16)) i_dut (
    .core_clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .capture_evt_in, .compare_evt_in, .capture_value_in, .chb_flag_in,
    .chb_ien_in, .capture_latch_out, .compare_pin_out, .compare_hit_out,
    .bus_irq_req_out, .bus_irq_level_out, .bus_arb_number_out, .irq_out
  );
  dat_chb_model i_chb (.core_clk_in, .rst_n_in, .set_in(chb_set),
    .clr_in(chb_clr), .chb_flag_out(chb_flag_in));

  initial forever #5 core_clk_in = ~core_clk_in;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] cw(logic f, logic [2:0] l, logic m,
      logic en, logic [1:0] md);
    return {16'h0, f, l, m, en, 8'h0, md};
  endfunction : cw

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = DAT_RESP_OKAY);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge core_clk_in);
    q_wr.push_back(r);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge core_clk_in);
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        ad = 1'h1;
        s_axi_awvalid_in <= 1'h0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wd = 1'h1;
        s_axi_wvalid_in <= 1'h0;
      end
    end
    do @(posedge core_clk_in); while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = DAT_RESP_OKAY);
    @(posedge core_clk_in);
    q_rd.push_back({r, d});
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do @(posedge core_clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'h0;
    do @(posedge core_clk_in); while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'h0;
  endtask : rd

  task automatic pulse(input logic cap, input logic [15:0] v);
    @(posedge core_clk_in);
    capture_evt_in <= cap;
    compare_evt_in <= !cap;
    capture_value_in <= v;
    @(posedge core_clk_in);
    capture_evt_in <= 1'h0;
    compare_evt_in <= 1'h0;
  endtask : pulse

  // Response checker; also cuts a hang short
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      e_rd = q_rd.pop_front();
      `CHK({s_axi_rresp_out, s_axi_rdata_out}, e_rd)
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      e_wr = q_wr.pop_front();
      `CHK(s_axi_bresp_out, e_wr)
    end
  end

  initial begin
    logic [31:0] r;
    repeat (12) @(posedge core_clk_in);
    rst_n_in <= 1'h1;
    chb_set <= 1'h1;
    chb_ien_in <= 1'h1;
    rd(DAT_CTRL_A_OFS, {16'h0, DAT_CTRL_A_RST});
    rd(8'h10, 32'h0, DAT_RESP_SLVERR);
    wr(8'h10, 32'h0, DAT_RESP_SLVERR);
    for (int l = 0; l < 8; l++) begin
      wr(DAT_CTRL_A_OFS, cw(1'h1, l[2:0], 1'h0, 1'h0, 2'h0));
      rd(DAT_CTRL_A_OFS, cw(1'h0, l[2:0], 1'h0, 1'h0, 2'h0));
      `CHK(bus_irq_level_out, l[2:0])
      `CHK(bus_irq_req_out, l != 0)
    end
    chb_set <= 1'h0;
    chb_clr <= 1'h1;
    chb_ien_in <= 1'h0;
    r = xs();
    wr(DAT_ARB_OFS, {29'h0, r[2:0]});
    wr(DAT_IRQ_MASK_OFS, 32'h1);
    wr(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, DAT_MODE_CAPTURE));
    rd(DAT_ARB_OFS, {29'h0, r[2:0]});
    `CHK(bus_arb_number_out, {1'h1, r[2:0]})
    `CHK(bus_irq_req_out, 1'h0)
    r = xs();
    pulse(1'h1, r[15:0]);
    pulse(1'h1, ~r[15:0]);
    rd(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, 2'h0));
    `CHK(capture_latch_out, ~r[15:0])
    `CHK(bus_irq_req_out, 1'h1)
    `CHK(irq_out, 1'h1)
    pulse(1'h1, r[15:0]);
    wr(DAT_CTRL_A_OFS, cw(1'h0, 3'h3, 1'h1, 1'h1, 2'h0));
    rd(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, 2'h0));
    wr(DAT_CTRL_A_OFS, cw(1'h0, 3'h3, 1'h1, 1'h1, 2'h0));
    rd(DAT_CTRL_A_OFS, cw(1'h0, 3'h3, 1'h1, 1'h1, 2'h0));
    `CHK(bus_irq_req_out, 1'h0)
    wr(DAT_IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge core_clk_in);
    `CHK(irq_out, 1'h0)
    wr(DAT_IRQ_STAT_OFS, 32'h3);
    rd(DAT_IRQ_STAT_OFS, 32'h0);
    wr(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, DAT_MODE_COMPARE));
    pulse(1'h0, 16'h0);
    pulse(1'h0, 16'h0);
    rd(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, 2'h1));
    `CHK(compare_pin_out, 1'h1)
    wr(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, DAT_MODE_TOGGLE));
    pulse(1'h0, 16'h0);
    rd(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, 2'h2));
    `CHK(compare_pin_out, 1'h0)
    wr(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, DAT_MODE_PULSE));
    pulse(1'h0, 16'h0);
    @(posedge core_clk_in);
    `CHK(compare_hit_out, 1'h1)
    rd(DAT_CTRL_A_OFS, cw(1'h1, 3'h3, 1'h1, 1'h1, 2'h3));
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
